// ---- core/cass_dvm_hs.sv ----
// cass_dvm_hs: four-phase entry/exit handshake for the dvm domain.
// assumes req and clk_en are synchronous to core_clk.
`timescale 1ns/100ps
module cass_dvm_hs
  import cass_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  cass_dvm_if.hs dvm
);
  cass_dvm_state_t state_reg, state_next;
  logic [SETTLE_W-1:0] cnt_reg, cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    // the ack only moves on enabled bus cycles
    if (dvm.clk_en) begin
      case (state_reg)
        CASS_OUT: begin
          if (dvm.req) begin
            state_next = CASS_JOIN;
            cnt_next = SETTLE_LOAD;
          end
        end
        CASS_JOIN: begin
          if (cnt_reg == SETTLE_ZERO) begin
            state_next = CASS_IN;
          end else begin
            cnt_next = cnt_reg - 4'h1;
          end
        end
        CASS_IN: begin
          if (!dvm.req) begin
            state_next = CASS_LEAVE;
          end
        end
        CASS_LEAVE: begin
          // exit is held until in-flight dvm traffic has drained
          if (!dvm.drain_busy) begin
            state_next = CASS_OUT;
          end
        end
        default: state_next = CASS_OUT;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= CASS_OUT;
      cnt_reg <= SETTLE_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign dvm.ack = (state_reg == CASS_IN) || (state_reg == CASS_LEAVE);
endmodule

// ---- core/cass_dvm_if.sv ----
// cass_dvm_if: carries the domain handshake between the port top and the
// handshake engine; both ends sit on core_clk.
`timescale 1ns/100ps
interface cass_dvm_if;
  logic req;
  logic ack;
  logic clk_en;
  logic drain_busy;
  modport ctrl (output req, output clk_en, output drain_busy, input ack);
  modport hs (input req, input clk_en, input drain_busy, output ack);
endinterface

// ---- core/cass_pkg.sv ----
// cass_pkg: constants and types for the coherent slave-port sideband block.
// assumes a single core_clk domain; no register bus, controls are ports or build parameters.
package cass_pkg;
  localparam int DATA_W = 256;
  localparam int CHK_W = DATA_W / 8;
  localparam int SLICE_W = 128;
  localparam int STRB_W = DATA_W / SLICE_W;
  localparam int ID_W = 11;
  localparam int TAG_W = 4;
  localparam int TAGS = 16;
  localparam int ADDR_W = 12;
  localparam int BEAT_LSB = 5;
  localparam int CHUNK_W = 8;
  localparam int NET_META_W = 24;
  // read user upper index per data width when metadata is on
  localparam int RUSER_HI_512 = 24;
  localparam int RUSER_HI_256 = 12;
  localparam int RUSER_HI_128 = 6;
  localparam int RUSER_HI_OFF = 0;
  localparam int USER_CHK_BIT = 0;
  localparam logic CHK_VALID_ON = 1'h1;
  localparam logic CHK_VALID_OFF = 1'h0;
  // settle time before the domain entry is acknowledged
  localparam int DVM_SETTLE_NS = 20;
  localparam int CLK_PERIOD_NS = 5;
  localparam int DVM_SETTLE_CYC =
    (DVM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD =
    SETTLE_W'(DVM_SETTLE_CYC - 1);
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 4'h0;

  typedef enum logic [1:0] {
    CASS_OUT = 2'h0,
    CASS_JOIN = 2'h1,
    CASS_IN = 2'h3,
    CASS_LEAVE = 2'h2
  } cass_dvm_state_t;

  function automatic int cass_ruser_hi(input int data_w, input bit meta);
    if (!meta) return RUSER_HI_OFF;
    if (data_w == 512) return RUSER_HI_512;
    if (data_w == 256) return RUSER_HI_256;
    return RUSER_HI_128;
  endfunction

  // odd parity per byte, one check bit per data byte
  function automatic logic [CHK_W-1:0] cass_byte_check(
    input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < CHK_W; i++) begin
      c[i] = ~(^d[i*8 +: 8]);
    end
    return c;
  endfunction
endpackage

// ---- core/cass_sideband.sv ----
// cass_sideband: sideband logic of the coherent slave port (data check,
// read user bus, read chunking, dvm handshake, wakeups, boot strap).
// assumes all inputs synchronous to core_clk; far side is a bus master.
`timescale 1ns/100ps
module cass_sideband
  import cass_pkg::*;
#(
  parameter bit DATA_CHECK_PARAM = 1'b1,
  parameter bit METADATA_PARAM = 1'b0,
  parameter int RUSER_HI = cass_ruser_hi(DATA_W, METADATA_PARAM)
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic port_clock_enable_in,
  input wire logic map_stall_disable_strap,
  output logic map_stall_enable_out,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [0:0] write_user_sideband_in,
  input wire logic [CHK_W-1:0] write_data_check_in,
  output logic net_wr_valid_out,
  input wire logic net_wr_ready_in,
  output logic [DATA_W-1:0] net_wr_data_out,
  output logic [CHK_W-1:0] net_wr_check_out,
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [ID_W-1:0] arid_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic read_chunk_enable_in,
  output logic net_rd_req_valid_out,
  input wire logic net_rd_req_ready_in,
  input wire logic net_rd_valid_in,
  output logic net_rd_ready_out,
  input wire logic [ID_W-1:0] net_rd_id_in,
  input wire logic [DATA_W-1:0] net_rd_data_in,
  input wire logic [CHK_W-1:0] net_rd_check_in,
  input wire logic [NET_META_W-1:0] net_rd_meta_in,
  input wire logic [ADDR_W-1:0] net_rd_addr_in,
  input wire logic [STRB_W-1:0] net_rd_slice_in,
  input wire logic net_rd_last_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [ID_W-1:0] rid_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic rlast_out,
  output logic [CHK_W-1:0] read_data_check_out,
  output logic [RUSER_HI:0] read_user_sideband_out,
  output logic chunk_valid_out,
  output logic [CHUNK_W-1:0] chunk_index_out,
  output logic [STRB_W-1:0] chunk_strobe_out,
  input wire logic coherency_request_in,
  output logic coherency_ack_out,
  input wire logic dvm_snoop_start_in,
  input wire logic dvm_snoop_busy_in,
  output logic snoop_wake_out,
  input wire logic master_wake_in,
  output logic net_wake_out
);
  localparam int RU_W = RUSER_HI + 1;
  cass_dvm_if dvm_bus ();

  // strap group: caught on the first cycle after reset release
  logic strap_taken_reg, strap_taken_next;
  logic stall_en_reg, stall_en_next;

  always_comb begin
    strap_taken_next = 1'b1;
    stall_en_next = stall_en_reg;
    if (!strap_taken_reg) begin
      stall_en_next = !map_stall_disable_strap;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strap_taken_reg <= 1'b0;
      stall_en_reg <= 1'b1;
    end else begin
      strap_taken_reg <= strap_taken_next;
      stall_en_reg <= stall_en_next;
    end
  end

  assign map_stall_enable_out = stall_en_reg;

  // write group: one registered stage toward the network
  logic wv_reg, wv_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic [CHK_W-1:0] wc_reg, wc_next;
  logic w_take;

  assign wready_out = port_clock_enable_in && (!wv_reg || net_wr_ready_in);
  assign w_take = wvalid_in && wready_out;

  always_comb begin
    wv_next = wv_reg;
    wd_next = wd_reg;
    wc_next = wc_reg;
    if (wv_reg && net_wr_ready_in) begin
      wv_next = 1'b0;
    end
    if (w_take) begin
      wv_next = 1'b1;
      wd_next = wdata_in;
      // with checking disabled the user bit never reaches a decision
      if (DATA_CHECK_PARAM && write_user_sideband_in[USER_CHK_BIT]) begin
        wc_next = write_data_check_in;
      end else if (DATA_CHECK_PARAM) begin
        wc_next = cass_byte_check(wdata_in);
      end else begin
        wc_next = cass_byte_check(wdata_in);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wv_reg <= 1'b0;
      wd_reg <= '0;
      wc_reg <= '0;
    end else begin
      wv_reg <= wv_next;
      wd_reg <= wd_next;
      wc_reg <= wc_next;
    end
  end

  assign net_wr_valid_out = wv_reg;
  assign net_wr_data_out = wd_reg;
  assign net_wr_check_out = wc_reg;

  // read request group: remember chunk enable and base beat per tag
  logic chunk_en_mem [TAGS];
  logic [ADDR_W-1:0] base_mem [TAGS];
  logic ar_take;
  logic [TAG_W-1:0] ar_tag, r_tag;

  assign arready_out = port_clock_enable_in && net_rd_req_ready_in;
  assign net_rd_req_valid_out = arvalid_in && port_clock_enable_in;
  assign ar_take = arvalid_in && arready_out;
  assign ar_tag = arid_in[TAG_W-1:0];
  assign r_tag = net_rd_id_in[TAG_W-1:0];

  // limitation: ids sharing low bits must not be outstanding together
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < TAGS; i++) begin
        chunk_en_mem[i] <= 1'b0;
        base_mem[i] <= '0;
      end
    end else if (ar_take) begin
      chunk_en_mem[ar_tag] <= read_chunk_enable_in;
      base_mem[ar_tag] <= araddr_in;
    end
  end

  // read data group: registered beat toward the master
  logic rv_reg, rv_next;
  logic [ID_W-1:0] rid_reg, rid_next;
  logic [DATA_W-1:0] rd_reg, rd_next;
  logic rl_reg, rl_next;
  logic [CHK_W-1:0] rc_reg, rc_next;
  logic [RUSER_HI:0] ru_reg, ru_next;
  logic cv_reg, cv_next;
  logic [CHUNK_W-1:0] cn_reg, cn_next;
  logic [STRB_W-1:0] cs_reg, cs_next;
  logic r_take, r_pop;
  logic [ADDR_W-1:0] beat_diff;

  assign r_pop = rv_reg && rready_in && port_clock_enable_in;
  assign net_rd_ready_out = !rv_reg || r_pop;
  assign r_take = net_rd_valid_in && net_rd_ready_out;
  assign beat_diff = (net_rd_addr_in >> BEAT_LSB)
                   - (base_mem[r_tag] >> BEAT_LSB);

  always_comb begin
    rv_next = rv_reg;
    rid_next = rid_reg;
    rd_next = rd_reg;
    rl_next = rl_reg;
    rc_next = rc_reg;
    ru_next = ru_reg;
    cv_next = cv_reg;
    cn_next = cn_reg;
    cs_next = cs_reg;
    if (r_pop) begin
      rv_next = 1'b0;
    end
    if (r_take) begin
      rv_next = 1'b1;
      rid_next = net_rd_id_in;
      rd_next = net_rd_data_in;
      rl_next = net_rd_last_in;
      rc_next = net_rd_check_in;
      // a cast keeps the select legal when the user bus is one bit wide
      ru_next = RU_W'({net_rd_meta_in, 1'b0});
      ru_next[USER_CHK_BIT] = DATA_CHECK_PARAM ? CHK_VALID_ON
                                               : CHK_VALID_OFF;
      if (chunk_en_mem[r_tag]) begin
        cv_next = 1'b1;
        cn_next = beat_diff[CHUNK_W-1:0];
        cs_next = net_rd_slice_in;
      end else begin
        // unchunked reads carry whole beats, returned as they arrive
        cv_next = 1'b0;
        cn_next = '0;
        cs_next = '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rv_reg <= 1'b0;
      rid_reg <= '0;
      rd_reg <= '0;
      rl_reg <= 1'b0;
      rc_reg <= '0;
      ru_reg <= '0;
      cv_reg <= 1'b0;
      cn_reg <= '0;
      cs_reg <= '0;
    end else begin
      rv_reg <= rv_next;
      rid_reg <= rid_next;
      rd_reg <= rd_next;
      rl_reg <= rl_next;
      rc_reg <= rc_next;
      ru_reg <= ru_next;
      cv_reg <= cv_next;
      cn_reg <= cn_next;
      cs_reg <= cs_next;
    end
  end

  assign rvalid_out = rv_reg;
  assign rid_out = rid_reg;
  assign rdata_out = rd_reg;
  assign rlast_out = rl_reg;
  assign read_data_check_out = rc_reg;
  assign read_user_sideband_out = ru_reg;
  assign chunk_valid_out = cv_reg && rv_reg;
  assign chunk_index_out = cn_reg;
  assign chunk_strobe_out = cs_reg;

  // wake group
  logic swake_reg, swake_next;
  logic mwake_reg, mwake_next;

  always_comb begin
    swake_next = dvm_snoop_start_in && coherency_ack_out;
    mwake_next = master_wake_in;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      swake_reg <= 1'b0;
      mwake_reg <= 1'b0;
    end else begin
      swake_reg <= swake_next;
      mwake_reg <= mwake_next;
    end
  end

  assign snoop_wake_out = swake_reg;
  assign net_wake_out = mwake_reg;

  // an unpopulated master ties its request low, so the domain stays out
  assign dvm_bus.req = coherency_request_in;
  assign dvm_bus.clk_en = port_clock_enable_in;
  assign dvm_bus.drain_busy = dvm_snoop_busy_in;
  assign coherency_ack_out = dvm_bus.ack;

  cass_dvm_hs u_dvm_hs (
    .core_clk(core_clk),
    .rst(rst),
    .dvm(dvm_bus.hs)
  );
endmodule

// ---- sim/cass_master_model.sv ----
// cass_master_model: far-side master that drives the domain request.
// assumes go comes from the bench, synchronous to core_clk.
`timescale 1ns/100ps
module cass_master_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic ack,
  output logic req
);
  logic req_reg;
  logic req_next;
  // request moves only once ack has caught up, so no phase is skipped
  always_comb begin
    req_next = req_reg;
    if (ack == req_reg) req_next = go;
  end
  always_ff @(posedge core_clk) begin
    if (rst) req_reg <= 1'h0;
    else req_reg <= req_next;
  end
  assign req = req_reg;
endmodule

// ---- sim/cass_sva.sv ----
// cass_sva: port checker for cass_sideband, attached by bind.
// assumes one core_clk domain, rst synchronous active high.
`timescale 1ns/100ps
module cass_sva
  import cass_pkg::*;
#(
  parameter bit DATA_CHECK_PARAM = 1'b1,
  parameter int RUSER_HI = 0
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic port_clock_enable_in,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic arready_out,
  input wire logic [0:0] write_user_sideband_in,
  input wire logic [CHK_W-1:0] write_data_check_in,
  input wire logic net_wr_valid_out,
  input wire logic net_wr_ready_in,
  input wire logic [CHK_W-1:0] net_wr_check_out,
  input wire logic rvalid_out,
  input wire logic [RUSER_HI:0] read_user_sideband_out,
  input wire logic chunk_valid_out,
  input wire logic coherency_request_in,
  input wire logic coherency_ack_out,
  input wire logic dvm_snoop_start_in,
  input wire logic snoop_wake_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_wr_forward: assert property (
    wvalid_in && wready_out && write_user_sideband_in[0] && DATA_CHECK_PARAM
    |=> net_wr_check_out == $past(write_data_check_in))
    else $error("write check not forwarded");
  a_wr_hold: assert property (
    net_wr_valid_out && !net_wr_ready_in
    |=> net_wr_valid_out && $stable(net_wr_check_out))
    else $error("stalled write check changed");
  a_ruser_flag: assert property (
    rvalid_out |-> read_user_sideband_out[0] == DATA_CHECK_PARAM)
    else $error("read user flag wrong");
  a_chunk_valid: assert property (
    chunk_valid_out |-> rvalid_out)
    else $error("chunk valid without read beat");
  a_ack_rise: assert property (
    $rose(coherency_ack_out) |-> coherency_request_in)
    else $error("ack rose without request");
  a_ack_fall: assert property (
    $fell(coherency_ack_out) |-> !coherency_request_in)
    else $error("ack fell while request high");
  a_clk_gate: assert property (
    !port_clock_enable_in |-> !wready_out && !arready_out)
    else $error("ready while clock enable low");
  a_snoop_wake: assert property (
    dvm_snoop_start_in && coherency_ack_out |=> snoop_wake_out)
    else $error("snoop wake missing");
endmodule
bind cass_sideband cass_sva #(.DATA_CHECK_PARAM(DATA_CHECK_PARAM),
  .RUSER_HI(RUSER_HI)) cass_sva_inst (.core_clk, .rst,
  .port_clock_enable_in, .wvalid_in, .wready_out, .arready_out,
  .write_user_sideband_in, .write_data_check_in, .net_wr_valid_out,
  .net_wr_ready_in, .net_wr_check_out, .rvalid_out,
  .read_user_sideband_out, .chunk_valid_out, .coherency_request_in,
  .coherency_ack_out, .dvm_snoop_start_in, .snoop_wake_out);

// ---- sim/tb.sv ----
// tb: self-checking bench for cass_sideband with a master model.
// assumes 200 MHz core_clk; main build with data checking on and metadata off.
`timescale 1ns/100ps
module tb;
  import cass_pkg::*;
  typedef struct packed {
    logic rd;
    logic u;
    logic [6:0] b;
    logic [31:0] c;
    logic [31:0] e;
  } cass_row_t;
  logic core_clk = 1'h0, rst = 1'h1, en = 1'h1, strap = 1'h1, mse;
  logic wv = 1'h0, wr, nwr = 1'h1, arv = 1'h0, ace = 1'h0, nrv = 1'h0;
  logic cv, req, ack, go = 1'h0, ss = 1'h0, sb = 1'h0, sw, mw = 1'h0, nw;
  logic [DATA_W-1:0] wd = '0, nrd = '0;
  logic [CHK_W-1:0] wc = '0, nwc;
  logic [0:0] wu = '0, ru;
  logic [ID_W-1:0] arid = '0, nrid = '0;
  logic [ADDR_W-1:0] nra = '0;
  logic [STRB_W-1:0] nrs = '0, cs;
  logic [CHUNK_W-1:0] ci;
  logic nwv, arr, nrqv, nrr, rv, rl, ack2;
  logic [DATA_W-1:0] nwd, rdo;
  logic [CHK_W-1:0] rdc, nwc2;
  logic [ID_W-1:0] rido;
  logic [RUSER_HI_256:0] ru2;
  logic [NET_META_W-1:0] nrm = '0;
  int miscompares = 0, n_tests = 0;
  cass_row_t rows [6];
  always #2.5 core_clk = ~core_clk;
  cass_sideband cass_sideband_inst (.core_clk, .rst,
    .port_clock_enable_in(en), .map_stall_disable_strap(strap),
    .map_stall_enable_out(mse), .wvalid_in(wv), .wready_out(wr),
    .wdata_in(wd), .write_user_sideband_in(wu), .write_data_check_in(wc),
    .net_wr_valid_out(nwv), .net_wr_ready_in(nwr), .net_wr_data_out(nwd),
    .net_wr_check_out(nwc), .arvalid_in(arv), .arready_out(arr),
    .arid_in(arid), .araddr_in(12'h020), .read_chunk_enable_in(ace),
    .net_rd_req_valid_out(nrqv), .net_rd_req_ready_in(1'h1),
    .net_rd_valid_in(nrv), .net_rd_ready_out(nrr), .net_rd_id_in(nrid),
    .net_rd_data_in(nrd), .net_rd_check_in(wc), .net_rd_meta_in(nrm),
    .net_rd_addr_in(nra), .net_rd_slice_in(nrs), .net_rd_last_in(1'h1),
    .rvalid_out(rv), .rready_in(1'h1), .rid_out(rido), .rdata_out(rdo),
    .rlast_out(rl), .read_data_check_out(rdc), .read_user_sideband_out(ru),
    .chunk_valid_out(cv), .chunk_index_out(ci), .chunk_strobe_out(cs),
    .coherency_request_in(req), .coherency_ack_out(ack),
    .dvm_snoop_start_in(ss), .dvm_snoop_busy_in(sb),
    .snoop_wake_out(sw), .master_wake_in(mw), .net_wake_out(nw));
  // second build: checking off, metadata on, no master on the request
  cass_sideband #(.DATA_CHECK_PARAM(1'b0), .METADATA_PARAM(1'b1))
    cass_sideband_nochk_inst (.core_clk, .rst,
    .port_clock_enable_in(en), .map_stall_disable_strap(strap),
    .map_stall_enable_out(), .wvalid_in(wv), .wready_out(),
    .wdata_in(wd), .write_user_sideband_in(wu), .write_data_check_in(wc),
    .net_wr_valid_out(), .net_wr_ready_in(nwr), .net_wr_data_out(),
    .net_wr_check_out(nwc2), .arvalid_in(arv), .arready_out(),
    .arid_in(arid), .araddr_in(12'h020), .read_chunk_enable_in(ace),
    .net_rd_req_valid_out(), .net_rd_req_ready_in(1'h1),
    .net_rd_valid_in(nrv), .net_rd_ready_out(), .net_rd_id_in(nrid),
    .net_rd_data_in(nrd), .net_rd_check_in(wc), .net_rd_meta_in(nrm),
    .net_rd_addr_in(nra), .net_rd_slice_in(nrs), .net_rd_last_in(1'h1),
    .rvalid_out(), .rready_in(1'h1), .rid_out(), .rdata_out(),
    .rlast_out(), .read_data_check_out(), .read_user_sideband_out(ru2),
    .chunk_valid_out(), .chunk_index_out(), .chunk_strobe_out(),
    .coherency_request_in(1'h0), .coherency_ack_out(ack2),
    .dvm_snoop_start_in(ss), .dvm_snoop_busy_in(sb),
    .snoop_wake_out(), .master_wake_in(mw), .net_wake_out());
  cass_master_model cass_master_model_inst (.core_clk, .rst, .go, .ack,
    .req);
  task automatic chk(input string n, input logic [31:0] x, g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one write beat, or one read request plus its single network beat
  task automatic run(input cass_row_t r);
    if (!r.rd) begin
      wv <= 1'h1;
      wu <= r.u;
      wd <= {32{r.b[0], 7'h00}};
      wc <= r.c;
      @(posedge core_clk);
      wv <= 1'h0;
      #1 chk("wr_check", r.e, nwc);
      chk("wr_valid", 32'h1, nwv);
      chk("wr_data", {r.b[0], 7'h00}, nwd[7:0]);
      chk("wr_check_off", r.b[0] ? 32'h0 : 32'hFFFFFFFF, nwc2);
    end else begin
      arv <= 1'h1;
      ace <= r.u;
      arid <= ID_W'(r.b);
      @(posedge core_clk);
      arv <= 1'h0;
      nrv <= 1'h1;
      nrid <= arid;
      nra <= {r.b, 5'h00};
      nrs <= r.c[1:0];
      nrm <= r.c[NET_META_W-1:0];
      nrd <= {8{r.c}};
      @(posedge core_clk);
      nrv <= 1'h0;
      #1 chk("chunk_valid", r.u, cv);
      chk("chunk_index", r.e, ci);
      chk("chunk_strobe", r.u ? r.c : 32'h0, cs);
      chk("ruser0", 32'h1, ru);
      chk("rvalid", 32'h1, rv);
      chk("rid", ID_W'(r.b), rido);
      chk("rdata", r.c, rdo[DATA_W-1 -: 32]);
      chk("rlast", 32'h1, rl);
      chk("rd_check", wc, rdc);
      chk("rd_ready", 32'h1, nrr);
      chk("ruser_meta", {r.c[11:0], 1'h0}, ru2);
    end
  endtask
  task automatic wait_ack(input logic v);
    int k;
    k = 0;
    while (ack !== v && k < 20) begin
      @(posedge core_clk);
      #1 k++;
    end
    chk("ack", v, ack);
  endtask
  initial begin
    rows[0] = '{1'h0, 1'h0, 7'h00, 32'h12345678, 32'hFFFFFFFF};
    rows[1] = '{1'h0, 1'h0, 7'h01, 32'h0000FFFF, 32'h0};
    rows[2] = '{1'h0, 1'h1, 7'h00, 32'hA5A5A5A5, 32'hA5A5A5A5};
    rows[3] = '{1'h1, 1'h1, 7'h01, 32'h1, 32'h0};
    rows[4] = '{1'h1, 1'h1, 7'h03, 32'h2, 32'h2};
    rows[5] = '{1'h1, 1'h0, 7'h02, 32'h3, 32'h0};
    repeat (8) @(posedge core_clk);
    chk("ack_rst", 32'h0, ack);
    chk("stall_rst", 32'h1, mse);
    rst <= 1'h0;
    repeat (3) @(posedge core_clk);
    #1 chk("map_stall", 32'h0, mse);
    chk("ruser_w", RUSER_HI_OFF + 1,
      $bits(cass_sideband_inst.read_user_sideband_out));
    chk("ruser_w_meta", RUSER_HI_256 + 1,
      $bits(cass_sideband_nochk_inst.read_user_sideband_out));
    foreach (rows[i]) run(rows[i]);
    nwr <= 1'h0;
    run(rows[2]);
    chk("wready_full", 32'h0, wr);
    en <= 1'h0;
    nwr <= 1'h1;
    arv <= 1'h1;
    @(posedge core_clk);
    #1 chk("wready_gated", 32'h0, wr);
    chk("arready_gated", 32'h0, arr);
    chk("ar_req_gated", 32'h0, nrqv);
    en <= 1'h1;
    #1 chk("ar_req_pass", 32'h1, nrqv);
    chk("arready_pass", 32'h1, arr);
    arv <= 1'h0;
    go <= 1'h1;
    repeat (2) @(posedge core_clk);
    #1 chk("ack_early", 32'h0, ack);
    wait_ack(1'h1);
    ss <= 1'h1;
    sb <= 1'h1;
    mw <= 1'h1;
    @(posedge core_clk);
    #1 chk("snoop_wake", 32'h1, sw);
    chk("net_wake", 32'h1, nw);
    ss <= 1'h0;
    go <= 1'h0;
    repeat (6) @(posedge core_clk);
    #1 chk("ack_hold", 32'h1, ack);
    sb <= 1'h0;
    wait_ack(1'h0);
    chk("ack_absent", 32'h0, ack2);
    // mid-run reset with the strap low: the stall must come back
    strap <= 1'h0;
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1 chk("stall_rerst", 32'h1, mse);
    chk("ack_rerst", 32'h0, ack);
    tally_and_finish;
  end
  // the sequence needs about 40 cycles; fifty times that means a hang
  initial begin
    #10000;
    miscompares++;
    tally_and_finish;
  end
endmodule
